// [desc_gate_check.sv]
// descriptor type decoder and call-gate privilege checker
// assumes a core-side master on the plain register port, core clock
//
// Strobed register access and the register addresses were left to the implementer.
`include "desc_gate_cfg.svh"

// ****************************************************************
// descriptor type decode and gate privilege check
// ****************************************************************
// What this block does
// - Bit 12 clear decodes the type field as system or gate, set decodes it as code or data.
// - System types map 0000/1000/1010/1101 reserved, 0001/0011/1001/1011 task states, 0010 local table.
// - Gate types are 0100/1100 call, 0101 task, 0110/1110 interrupt and 0111/1111 trap gates.
// - Application types with bit 11 clear are data with expand-down, writable and accessed bits.
// - Application types with bit 11 set are code with conforming, readable and accessed bits.
// - Gate offset is upper[31:16] with lower[15:0], and the target selector is lower[31:16].
// - The parameter count is upper[4:0] and gives how many words are copied between stacks.
// - The gate present flag is bit 15, its privilege bits 14:13 and its type bits 11:8.
// - A call or jump through a present call gate fetches the code descriptor named by the gate selector.
// - A gate transfer weighs current, requested, gate and destination privilege levels.
// - The larger of current and requested level must not exceed the gate level.
// - A jump through a call gate needs destination level equal to current level.
// - A call through a call gate needs destination level at most the current level.
// - A conforming code destination is reached directly without any gate.
// - A gate or destination descriptor with present flag clear sets the not-present fault; the conforming bypass skips that check.
module desc_gate_check
  import desc_gate_pkg::*;
(
  input  wire logic        sys_clk,    // core clock
  input  wire logic        rst_b,      // synchronous reset, low
  input  wire logic [3:0]  reg_addr,   // register index
  input  wire logic [31:0] reg_wdata,  // write data
  input  wire logic        reg_wr,     // write strobe
  input  wire logic        reg_rd,     // read strobe
  output logic      [31:0] reg_rdata,  // read data, cycle after strobe
  output logic             fetch_req,  // pulse: fetch destination descriptor
  output logic      [15:0] fetch_sel,  // selector to fetch
  output logic             chk_done,   // pulse: check finished
  output logic             chk_pass    // result of last check
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic desc_kind_t kind_of(input logic [31:0] hi);
    logic [3:0] t;
    t = hi[`TYPE_HI:`TYPE_LO];
    kind_of = K_RESERVED;
    if (hi[`S_BIT]) begin
      kind_of = t[`TB_EXEC] ? K_CODE : K_DATA;
    end else begin
      case (t)
        `T_TSS16_AV:  kind_of = K_TSS16_AVAIL;
        `T_LDT:       kind_of = K_LDT;
        `T_TSS16_BSY: kind_of = K_TSS16_BUSY;
        `T_CALL16:    kind_of = K_CALL16;
        `T_TASKG:     kind_of = K_TASK_GATE;
        `T_INT16:     kind_of = K_INT16;
        `T_TRAP16:    kind_of = K_TRAP16;
        `T_TSS32_AV:  kind_of = K_TSS32_AVAIL;
        `T_TSS32_BSY: kind_of = K_TSS32_BUSY;
        `T_CALL32:    kind_of = K_CALL32;
        `T_INT32:     kind_of = K_INT32;
        `T_TRAP32:    kind_of = K_TRAP32;
        default:      kind_of = K_RESERVED;
      endcase
    end
  endfunction

  // the larger level value is the less privileged one
  function automatic logic [1:0] max2(input logic [1:0] a, input logic [1:0] b);
    max2 = (a > b) ? a : b;
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [31:0] desc_lo_r;   // gate lower word
  logic [31:0] desc_hi_r;   // gate upper word
  logic [31:0] dest_hi_r;   // destination upper word
  logic [1:0]  cpl_r;       // current level
  logic        is_call_r;   // call, not jump
  logic [15:0] rsel_r;      // selector used for transfer
  logic        start_pls;
  chk_state_t  state_r;
  logic [5:0]  fault_r;     // sticky-per-check fault flags
  logic        bypass_r;    // conforming bypass taken

  desc_kind_t  gate_kind;
  desc_kind_t  dest_kind;
  logic        gate_is_call;
  logic [1:0]  gate_dpl;
  logic [1:0]  dest_dpl;
  logic [1:0]  requested_priv_level;
  logic        conf_dest;
  logic [31:0] tgt_off;
  logic [15:0] tgt_sel;
  logic [4:0]  pcount;
  logic        gate_pres;

  assign gate_kind = kind_of(desc_hi_r);
  assign dest_kind = kind_of(dest_hi_r);
  assign gate_pres = desc_hi_r[`PRES_BIT];
  assign gate_dpl  = desc_hi_r[`DPL_HI:`DPL_LO];
  assign dest_dpl  = dest_hi_r[`DPL_HI:`DPL_LO];
  assign requested_priv_level       = rsel_r[`RPL_HI:`RPL_LO];
  assign gate_is_call = (gate_kind == K_CALL16) || (gate_kind == K_CALL32);
  assign tgt_off = {desc_hi_r[`OFFS_HI:`OFFS_MID], desc_lo_r[`OFFS_LO_HI:`OFFS_LO_LO]};
  assign tgt_sel = desc_lo_r[`SEL_HI:`SEL_LO];
  assign pcount  = desc_hi_r[`PCNT_HI:`PCNT_LO];
  assign conf_dest = (kind_of(desc_hi_r) == K_CODE) && desc_hi_r[`TYPE_LO + `TB_CONF_EXP];
  // start is only a control write with bit 0 set; it never lingers past that cycle
  assign start_pls = reg_wr && (reg_addr == `A_CTRL) && reg_wdata[`C_START];

  // software writes of descriptor words and control
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      desc_lo_r <= 32'h0000_0000;
      desc_hi_r <= 32'h0000_0000;
      cpl_r     <= 2'h0;
      is_call_r <= 1'b0;
      rsel_r    <= 16'h0000;
    end else if (reg_wr) begin
      if (reg_addr == `A_DESC_LO) begin
        desc_lo_r <= reg_wdata;
      end else if (reg_addr == `A_DESC_HI) begin
        desc_hi_r <= reg_wdata;
      end else if (reg_addr == `A_CTRL) begin
        cpl_r     <= reg_wdata[`C_CPL_HI:`C_CPL_LO];
        is_call_r <= reg_wdata[`C_IS_CALL];
        rsel_r    <= reg_wdata[`C_RSEL_HI:`C_RSEL_LO];
      end
    end
  end

  // destination descriptor word returned by the fetch
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dest_hi_r <= 32'h0000_0000;
    end else if (reg_wr && reg_addr == `A_DEST_HI) begin
      dest_hi_r <= reg_wdata;
    end
  end

  // ****************************************************************
  // check sequencer
  // ****************************************************************
  // fault bits: 0 type, 1 not present, 2 gate priv, 3 jump dest, 4 call dest, 5 dest not code
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_r   <= ST_IDLE;
      fault_r   <= 6'h00;
      bypass_r  <= 1'b0;
      fetch_req <= 1'b0;
      fetch_sel <= 16'h0000;
      chk_done  <= 1'b0;
      chk_pass  <= 1'b0;
    end else begin
      fetch_req <= 1'b0;
      chk_done  <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start_pls) begin
            fault_r  <= 6'h00;
            bypass_r <= 1'b0;
            if (conf_dest) begin
              bypass_r <= 1'b1;
              state_r  <= ST_DONE;
            end else begin
              fault_r[0] <= !gate_is_call;
              fault_r[1] <= !gate_pres;
              fault_r[2] <= max2(cpl_r, requested_priv_level) > gate_dpl;
              if (gate_is_call && gate_pres) begin
                fetch_req <= 1'b1;
                fetch_sel <= tgt_sel;
                state_r   <= ST_WAIT_DEST;
              end else begin
                state_r <= ST_DONE;
              end
            end
          end
        end
        ST_WAIT_DEST: begin
          // a start here is dropped, but the control write still reloads cpl_r, is_call_r and rsel_r
          if (reg_wr && reg_addr == `A_DEST_HI) begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          // the destination word is final here, so its checks run in this cycle
          if (!bypass_r && gate_is_call && gate_pres) begin
            fault_r[3] <= !is_call_r && (dest_dpl != cpl_r);
            fault_r[4] <= is_call_r && (dest_dpl > cpl_r);
            fault_r[5] <= dest_kind != K_CODE;
            if (!dest_hi_r[`PRES_BIT]) begin
              fault_r[1] <= 1'b1;
            end
            chk_pass <= (fault_r[2:0] == 3'h0) && (dest_kind == K_CODE)
                        && dest_hi_r[`PRES_BIT]
                        && (is_call_r ? (dest_dpl <= cpl_r) : (dest_dpl == cpl_r));
          end else begin
            chk_pass <= bypass_r || (fault_r == 6'h00);
          end
          chk_done <= 1'b1;
          state_r  <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  // read data valid only the cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (reg_addr == `A_DESC_LO) begin
        reg_rdata <= desc_lo_r;
      end else if (reg_addr == `A_DESC_HI) begin
        reg_rdata <= desc_hi_r;
      end else if (reg_addr == `A_CTRL) begin
        reg_rdata <= {rsel_r, 12'h000, cpl_r, is_call_r, 1'b0};
      end else if (reg_addr == `A_STATUS) begin
        // status: kinds, bypass, pass, busy, faults, present, gate level
        reg_rdata <= {10'h000, 5'(gate_kind), 5'(dest_kind), bypass_r, chk_pass,
                      (state_r != ST_IDLE), fault_r, gate_pres, gate_dpl};
      end else if (reg_addr == `A_TARGET) begin
        reg_rdata <= tgt_off;
      end else if (reg_addr == `A_SELPC) begin
        reg_rdata <= {tgt_sel, 11'h000, pcount};
      end else if (reg_addr == `A_DEST_HI) begin
        reg_rdata <= dest_hi_r;
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end else begin
      // idle cycles read zero so a stale word never looks like an answer
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  // fetch names gate selector
  AST_FETCH_SEL: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fetch_req |-> fetch_sel == $past(desc_lo_r[`SEL_HI:`SEL_LO]))
    else $error("fetch selector not gate selector");
  AST_FETCH_REQ: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_r == ST_IDLE && start_pls && !conf_dest && gate_is_call && desc_hi_r[`PRES_BIT])
      |=> (fetch_req && state_r == ST_WAIT_DEST))
    else $error("present call gate did not fetch its destination");
  AST_NO_FETCH: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_r == ST_IDLE && start_pls && !conf_dest && !desc_hi_r[`PRES_BIT])
      |=> (!fetch_req && state_r == ST_DONE))
    else $error("absent gate started a fetch");
  AST_GATE_PRIV: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_r == ST_IDLE && start_pls && !conf_dest && max2(cpl_r, requested_priv_level) > gate_dpl)
      |=> fault_r[2])
    else $error("gate privilege fault missed");
  AST_PRIV_PASS: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (chk_done && chk_pass && !bypass_r) |-> max2(cpl_r, requested_priv_level) <= gate_dpl)
    else $error("gate transfer passed above gate level");
  AST_JMP_DEST: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (chk_done && chk_pass && !bypass_r && !is_call_r) |-> dest_dpl == cpl_r)
    else $error("jump passed with unequal level");
  AST_CALL_DEST: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (chk_done && chk_pass && !bypass_r && is_call_r) |-> dest_dpl <= cpl_r)
    else $error("call passed to less privileged code");
  AST_DEST_CODE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (chk_done && chk_pass && !bypass_r) |-> (dest_kind == K_CODE && dest_hi_r[`PRES_BIT]))
    else $error("gate transfer passed to absent or non-code destination");
  AST_TYPE_FAULT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_r == ST_IDLE && start_pls && !conf_dest && !gate_is_call)
      |=> ##1 (chk_done && !chk_pass))
    else $error("non-gate type passed");
  AST_NOT_PRES: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_r == ST_IDLE && start_pls && !conf_dest && !gate_pres) |=> fault_r[1])
    else $error("not present missed");
  AST_BYPASS: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_r == ST_IDLE && start_pls && conf_dest) |=> ##1 (chk_done && chk_pass))
    else $error("conforming bypass not taken");
  AST_OFFSET: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $past(reg_rd) && $past(reg_addr) == `A_TARGET
      |-> reg_rdata == {$past(desc_hi_r[`OFFS_HI:`OFFS_MID]), $past(desc_lo_r[`OFFS_LO_HI:`OFFS_LO_LO])})
    else $error("target offset read wrong");
  AST_PCOUNT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ($past(reg_rd) && $past(reg_addr) == `A_SELPC)
      |-> reg_rdata[`PCNT_HI:`PCNT_LO] == $past(desc_hi_r[`PCNT_HI:`PCNT_LO]))
    else $error("parameter count read wrong");
  AST_APP_SPLIT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    desc_hi_r[`S_BIT] |-> (gate_kind == K_DATA || gate_kind == K_CODE))
    else $error("application descriptor decoded as system kind");
  AST_DATA_KIND: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (desc_hi_r[`S_BIT] && !desc_hi_r[`TYPE_LO + `TB_EXEC]) |-> gate_kind == K_DATA)
    else $error("data kind misdecoded");
  AST_CODE_KIND: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (desc_hi_r[`S_BIT] && desc_hi_r[`TYPE_LO + `TB_EXEC]) |-> gate_kind == K_CODE)
    else $error("code kind misdecoded");
  AST_RES_KIND: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!desc_hi_r[`S_BIT] && (desc_hi_r[`TYPE_HI:`TYPE_LO] inside {`T_RES0, `T_RES8, `T_RESA, `T_RESD}))
      |-> gate_kind == K_RESERVED)
    else $error("reserved system code misdecoded");
  AST_CALL_KIND: assert property (@(posedge sys_clk) disable iff (!rst_b)
    gate_is_call == (!desc_hi_r[`S_BIT]
      && (desc_hi_r[`TYPE_HI:`TYPE_LO] inside {`T_CALL16, `T_CALL32})))
    else $error("call gate code misdecoded");

endmodule

// [desc_gate_cfg.svh]
// descriptor field positions, type codes and register-map constants
// assumes inclusion by the decoder module; the package does not include it
`ifndef DESC_GATE_CFG_SVH
`define DESC_GATE_CFG_SVH
// descriptor upper and lower word fields and selector level bits
`define S_BIT        12
`define TYPE_HI      11
`define TYPE_LO      8
`define PRES_BIT     15
`define DPL_HI       14
`define DPL_LO       13
`define PCNT_HI      4
`define PCNT_LO      0
`define OFFS_HI      31
`define OFFS_MID     16
`define OFFS_LO_HI   15
`define OFFS_LO_LO   0
`define SEL_HI       31
`define SEL_LO       16
`define RPL_HI       1
`define RPL_LO       0
// type bits
`define TB_EXEC      3
`define TB_CONF_EXP  2
`define TB_RW        1
`define TB_ACC       0
// system and gate type codes
`define T_RES0       4'h0
`define T_TSS16_AV   4'h1
`define T_LDT        4'h2
`define T_TSS16_BSY  4'h3
`define T_CALL16     4'h4
`define T_TASKG      4'h5
`define T_INT16      4'h6
`define T_TRAP16     4'h7
`define T_RES8       4'h8
`define T_TSS32_AV   4'h9
`define T_RESA       4'hA
`define T_TSS32_BSY  4'hB
`define T_CALL32     4'hC
`define T_RESD       4'hD
`define T_INT32      4'hE
`define T_TRAP32     4'hF
// register offsets
`define A_DESC_LO    4'h0
`define A_DESC_HI    4'h1
`define A_CTRL       4'h2
`define A_STATUS     4'h3
`define A_TARGET     4'h4
`define A_SELPC      4'h5
`define A_DEST_HI    4'h6
// control register bits
`define C_START      0
`define C_IS_CALL    1
`define C_CPL_LO     2
`define C_CPL_HI     3
`define C_RSEL_LO    16
`define C_RSEL_HI    31
`endif

// [desc_gate_pkg.sv]
// types shared by the descriptor gate checker
// assumes the cfg header defines every field position
package desc_gate_pkg;
  typedef enum logic [4:0] {
    K_RESERVED, K_TSS16_AVAIL, K_LDT, K_TSS16_BUSY, K_CALL16, K_TASK_GATE,
    K_INT16, K_TRAP16, K_TSS32_AVAIL, K_TSS32_BUSY, K_CALL32, K_INT32,
    K_TRAP32, K_DATA, K_CODE
  } desc_kind_t;
  typedef enum {
    ST_IDLE, ST_WAIT_DEST, ST_DONE
  } chk_state_t;
endpackage

// [tb_desc_gate_check.sv]
// self-checking bench for the descriptor type decoder and gate checker
// assumes the checker alone on its register port; bench acts as core master
module tb_desc_gate_check
  import desc_gate_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk, rst_b, reg_wr, reg_rd, fetch_req, chk_done, chk_pass;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd, lo, up, dst, ctl, rng;
  logic [15:0] fetch_sel;
  logic [1:0]  current_priv_level, requested_priv_level, gdpl, ddpl, mx;
  logic        cg, conf, pexp;
  logic [5:0]  fex;
  int          err_count, total_checks, n, i;

  desc_gate_check dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fetch_req(fetch_req), .fetch_sel(fetch_sel), .chk_done(chk_done),
    .chk_pass(chk_pass));

  // free-running core clock, 10 ns
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // reference decode of an upper descriptor word
  function automatic desc_kind_t kind_of(input logic [31:0] w);
    if (w[12]) return w[11] ? K_CODE : K_DATA;
    case (w[11:8])
      4'h1: return K_TSS16_AVAIL;
      4'h2: return K_LDT;
      4'h3: return K_TSS16_BUSY;
      4'h4: return K_CALL16;
      4'h5: return K_TASK_GATE;
      4'h6: return K_INT16;
      4'h7: return K_TRAP16;
      4'h9: return K_TSS32_AVAIL;
      4'hb: return K_TSS32_BUSY;
      4'hc: return K_CALL32;
      4'he: return K_INT32;
      4'hf: return K_TRAP32;
      default: return K_RESERVED;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one-cycle write strobe; next call starts one edge later
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // read data only stand in the cycle after the strobe
  task automatic rdr(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    rd = reg_rdata;
  endtask

  // bounded wait, n counts cycles after the launching edge
  task automatic await_ev(input logic want_fetch);
    for (n = 1; n <= 8; n++) begin
      @(negedge sys_clk);
      if (want_fetch ? fetch_req === 1'b1 : chk_done === 1'b1) break;
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ************************************************************
  // watchdog: the whole run needs well under 20000 cycles
  // ************************************************************
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    $display("watchdog expired");
    conclude();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rng = 32'hc7b8_a8d5;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    chk("reset read data", 0, reg_rdata);
    chk("reset pulses", 0, {29'h0, fetch_req, chk_done, chk_pass});
    chk("reset selector", 0, {16'h0000, fetch_sel});
    $display("reset test done");
    // every type code with both descriptor-type settings, random other fields
    for (i = 0; i < 256; i++) begin
      rng = xs(rng);
      lo = rng;
      rng = xs(rng);
      up = rng;
      up[12:8] = i[4:0];
      up[7:5] = 3'b000;
      conf = up[12] & up[11] & up[10];
      if (conf) up[15] = 1'b1;
      rng = xs(rng);
      dst = rng;
      // conforming destinations are kept out of the gate path
      if (dst[12] & dst[11]) dst[10] = 1'b0;
      rng = xs(rng);
      ctl = {rng[31:16], 12'h000, rng[3:1], 1'b0};
      current_priv_level = ctl[3:2];
      requested_priv_level = ctl[17:16];
      gdpl = up[14:13];
      ddpl = dst[14:13];
      mx = (current_priv_level > requested_priv_level) ? current_priv_level : requested_priv_level;
      cg = !up[12] && up[10:8] == 3'b100;
      pexp = conf | (cg & up[15] & dst[15] & (mx <= gdpl) & dst[12] & dst[11]
             & (ctl[1] ? ddpl <= current_priv_level : ddpl == current_priv_level));
      // expected fault flags: type, not present, gate level, jump, call, not code
      fex[0] = !conf & !cg;
      fex[1] = !conf & (!up[15] | (cg & !dst[15]));
      fex[2] = !conf & (mx > gdpl);
      fex[3] = !conf & cg & up[15] & !ctl[1] & (ddpl != current_priv_level);
      fex[4] = !conf & cg & up[15] & ctl[1] & (ddpl > current_priv_level);
      fex[5] = !conf & cg & up[15] & !(dst[12] & dst[11]);
      wr(4'h0, lo);
      wr(4'h1, up);
      wr(4'h2, ctl);
      rdr(4'h0); chk("lower word", lo, rd);
      rdr(4'h1); chk("upper word", up, rd);
      rdr(4'h4); chk("target offset", {up[31:16], lo[15:0]}, rd);
      rdr(4'h5); chk("selector pcount", {lo[31:16], 11'h000, up[4:0]}, rd);
      rdr(4'h2); chk("control", ctl, rd);
      rdr(4'h3);
      chk("gate level", gdpl, rd[1:0]);
      chk("present", up[15], rd[2]);
      chk("gate kind", kind_of(up), rd[21:17]);
      wr(4'h2, ctl | 32'h0000_0001);
      if (cg && up[15]) begin
        await_ev(1'b1);
        chk("fetch latency", 1, n);
        chk("fetch selector", lo[31:16], fetch_sel);
        // a second start while busy must be ignored
        if (i % 8 == 4) begin
          wr(4'h2, ctl | 32'h0000_0001);
          @(negedge sys_clk);
          chk("busy start", 0, fetch_req);
        end
        wr(4'h6, dst);
      end
      await_ev(1'b0);
      chk("done latency", 2, n);
      chk("pass", pexp, chk_pass);
      rdr(4'h3);
      chk("status pass", pexp, rd[10]);
      chk("bypass", conf, rd[11]);
      chk("busy", 0, rd[9]);
      chk("faults", fex, rd[8:3]);
      if (cg && up[15]) chk("dest kind", kind_of(dst), rd[16:12]);
    end
    $display("decode and gate test done");
    // unmapped places ignore writes and read as zero
    for (i = 7; i < 16; i++) begin
      wr(i[3:0], 32'hffff_ffff);
      rdr(i[3:0]);
      chk("unmapped", 0, rd);
    end
    $display("unmapped test done");
    conclude();
  end
endmodule
